// File: rtl/link_regs_pkg.sv
package link_regs_pkg;
	// ***********************************************
	// register offsets (byte addresses)
	// ***********************************************
	localparam logic [7:0] LINK_CTRL_OFF = 8'h00; // link control word
	localparam logic [7:0] CYC_TIMER_OFF = 8'h04; // cycle timer
	localparam logic [7:0] AREQ_HI_OFF = 8'h08; // async filter, sources 32..62 + all
	localparam logic [7:0] AREQ_LO_OFF = 8'h0C; // async filter, sources 0..31
	localparam logic [7:0] PREQ_HI_OFF = 8'h10; // physical filter high
	localparam logic [7:0] PREQ_LO_OFF = 8'h14; // physical filter low
	localparam logic [7:0] PHYS_LIM_OFF = 8'h18; // physical range limit
	localparam logic [7:0] ATX_CTRL_OFF = 8'h20; // context 0 control, +stride per context
	localparam logic [7:0] ATX_PTR_OFF = 8'h24; // context 0 command pointer
	localparam logic [7:0] ATX_STRIDE = 8'h08; // request ctx 0, response ctx 1
	// ***********************************************
	// field positions
	// ***********************************************
	localparam int LC_MASTER = 0; // cycle master
	localparam int LC_EXT_SEL = 1; // external_tick_select
	localparam int LC_ENABLE = 2; // timer_count_enable
	localparam int LC_SOFT_RST = 3; // software_reset_bit, write-1 pulse
	localparam int ALL_BIT = 31; // accept-all bit in async filter high word, all-buses bit in physical filter high word
	localparam int CC_RUN = 15;
	localparam int CC_WAKE = 12;
	localparam int CC_DEAD = 11;
	localparam int CC_ACTIVE = 10;
	localparam int PTR_ADDR_LSB = 4; // descriptor_pointer lsb
	// ***********************************************
	// reset values and timing
	// ***********************************************
	localparam logic [31:0] ZERO_RST = 32'h0000_0000; // filters, limit, pointers
	localparam logic [4:0] EVT_RST = 5'h00;
	localparam int CLK_KHZ = 200000; // system clock
	localparam int OFFSET_RATE_KHZ = 24576; // offset counting rate
	localparam logic [17:0] ACC_MOD = 18'(CLK_KHZ);
	localparam logic [17:0] ACC_STEP = 18'(OFFSET_RATE_KHZ);
	localparam logic [11:0] OFFSET_LAST = 12'd3071; // 3072 counts per cycle
	localparam logic [12:0] COUNT_LAST = 13'd7999; // 8000 cycles per second
	// ***********************************************
	// types
	// ***********************************************
	typedef struct packed {
		logic [6:0] seconds_field;
		logic [12:0] cycle_number_field;
		logic [11:0] tick_within_cycle;
	} cycle_timer_s;
	typedef struct packed {
		logic valid; // one-cycle request header strobe
		logic resp; // packet is a response
		logic rom; // targets config ROM or bus management regs
		logic local_bus; // source sits on the local bus
		logic [5:0] src; // source node number
		logic [47:0] offset; // destination offset
	} req_hdr_s;
	typedef struct packed {
		logic done; // descriptor finished
		logic err; // descriptor failed
		logic last; // finished descriptor ends the program
		logic [4:0] code; // completion code
	} ctx_evt_s;
	typedef enum logic [2:0] {
		CTX_IDLE = 3'b001,
		CTX_ACTIVE = 3'b010,
		CTX_DEAD = 3'b100
	} ctx_state_e;
endpackage

// File: rtl/link_regs.sv
// Summary of operation
// - master cycle start carries timer contents
// - external tick clears the offset
// - offset holds at 3071 awaiting tick
// - slave loads received cycle start, else counts
// - resets leave cycle timer untouched
// - seconds advance every 8000 cycles
// - cycle advances on tick or 3072 offsets
// - offset counts 24.576 MHz, 3072 per cycle
// - unlisted request sources dropped, no acknowledge
// - responses and ROM/CSR requests bypass filter
// - bus reset clears filter except accept-all
// - enabled source below limit goes physical
// - ROM/CSR requests always physical
// - bus reset clears physical filter except all-buses
// - physical range is limit shifted 16, minus one
// - run bit starts each transmit context
// - wake bit resumes descriptor processing
// - dead on error, active while busy, code
// - pointer reports failing or last descriptor
`timescale 1ns/1ps
`default_nettype none
module link_regs (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	input wire logic EXT_8K_TICK_I,
	input wire logic CSP_VALID_I,
	input wire logic [31:0] CSP_DATA_I,
	output logic CSP_TX_O,
	output logic [31:0] CSP_TX_DATA_O,
	input wire logic BUS_RESET_I,
	input wire link_regs_pkg::req_hdr_s REQ_I,
	output logic REQ_STORE_O,
	output logic REQ_DROP_O,
	output logic REQ_PHYS_O,
	input wire link_regs_pkg::ctx_evt_s [1:0] CTX_EVT_I,
	output logic [1:0] CTX_ACTIVE_O,
	output logic [1:0][31:0] CTX_DESC_O
);
	// ***********************************************
	// helpers
	// ***********************************************
	// source lookup shared by both filters; node 63 only via accept-all
	function automatic logic src_enabled(input logic [31:0] hi, input logic [31:0] lo, input logic [5:0] src);
		logic [63:0] vec;
		vec = {hi, lo};
		return hi[link_regs_pkg::ALL_BIT] | vec[src];
	endfunction

	// ***********************************************
	// register bus decode
	// ***********************************************
	logic [2:0] lctrl_q; // master, ext select, enable
	logic soft_q; // one-cycle software reset
	link_regs_pkg::cycle_timer_s timer_q, timer_d;
	logic [31:0] areq_hi_q, areq_lo_q, preq_hi_q, preq_lo_q;
	logic [31:0] plim_q; // physical_range_limit
	logic [31:0] rdata_q;
	logic [1:0][31:0] ctx_ctrl; // assembled control words
	logic [1:0][31:0] ptr_q;
	logic wr_timer;
	assign wr_timer = WR_I && (ADDR_I == link_regs_pkg::CYC_TIMER_OFF);

	// link control; soft reset bit self-clears after one cycle
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lctrl_q <= 3'h0;
			soft_q <= 1'b0;
		end else begin
			soft_q <= WR_I && (ADDR_I == link_regs_pkg::LINK_CTRL_OFF) && WDATA_I[link_regs_pkg::LC_SOFT_RST];
			if (WR_I && (ADDR_I == link_regs_pkg::LINK_CTRL_OFF)) begin
				lctrl_q <= WDATA_I[2:0];
			end
		end
	end

	// read mux; unmapped addresses read zero
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		case (ADDR_I)
			link_regs_pkg::LINK_CTRL_OFF: rd_val = {29'h0, lctrl_q};
			link_regs_pkg::CYC_TIMER_OFF: rd_val = timer_q;
			link_regs_pkg::AREQ_HI_OFF: rd_val = areq_hi_q;
			link_regs_pkg::AREQ_LO_OFF: rd_val = areq_lo_q;
			link_regs_pkg::PREQ_HI_OFF: rd_val = preq_hi_q;
			link_regs_pkg::PREQ_LO_OFF: rd_val = preq_lo_q;
			link_regs_pkg::PHYS_LIM_OFF: rd_val = plim_q;
			link_regs_pkg::ATX_CTRL_OFF: rd_val = ctx_ctrl[0];
			link_regs_pkg::ATX_PTR_OFF: rd_val = ptr_q[0];
			link_regs_pkg::ATX_CTRL_OFF + link_regs_pkg::ATX_STRIDE: rd_val = ctx_ctrl[1];
			link_regs_pkg::ATX_PTR_OFF + link_regs_pkg::ATX_STRIDE: rd_val = ptr_q[1];
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= RD_I ? rd_val : 32'h0000_0000;
		end
	end
	assign RDATA_O = rdata_q;

	// ***********************************************
	// cycle timer
	// ***********************************************
	logic ext_s1_q, ext_s2_q, ext_s3_q; // external tick synchroniser + edge
	logic [17:0] acc_q; // fractional rate accumulator
	logic tick_q; // one offset count
	logic ext_pulse, ext_mode, cyc_inc;
	logic [18:0] acc_sum;

	// two flops before any use, third for the rising edge
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= EXT_8K_TICK_I;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	assign ext_pulse = ext_s2_q && !ext_s3_q && lctrl_q[link_regs_pkg::LC_ENABLE];
	// external select only counts while cycle master
	assign ext_mode = lctrl_q[link_regs_pkg::LC_MASTER] && lctrl_q[link_regs_pkg::LC_EXT_SEL];

	// average 24.576 MHz derived from 200 MHz; jitter is one clock, fine for a 125 us cycle
	assign acc_sum = {1'b0, acc_q} + {1'b0, link_regs_pkg::ACC_STEP};
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			acc_q <= 18'h00000;
			tick_q <= 1'b0;
		end else if (acc_sum >= {1'b0, link_regs_pkg::ACC_MOD}) begin
			acc_q <= 18'(acc_sum - {1'b0, link_regs_pkg::ACC_MOD});
			tick_q <= lctrl_q[link_regs_pkg::LC_ENABLE];
		end else begin
			acc_q <= acc_sum[17:0];
			tick_q <= 1'b0;
		end
	end

	// next timer value; software write wins, then received packet
	always_comb begin
		timer_d = timer_q;
		cyc_inc = 1'b0;
		if (wr_timer) begin
			timer_d = WDATA_I;
		end else if (!lctrl_q[link_regs_pkg::LC_MASTER] && CSP_VALID_I) begin
			timer_d = CSP_DATA_I;
		end else if (ext_mode) begin
			if (ext_pulse) begin
				timer_d.tick_within_cycle = 12'h000;
				cyc_inc = 1'b1;
			end else if (tick_q && (timer_q.tick_within_cycle != link_regs_pkg::OFFSET_LAST)) begin
				// stalls at the last count until the tick comes
				timer_d.tick_within_cycle = timer_q.tick_within_cycle + 12'h001;
			end
		end else if (tick_q) begin
			if (timer_q.tick_within_cycle == link_regs_pkg::OFFSET_LAST) begin
				timer_d.tick_within_cycle = 12'h000;
				cyc_inc = 1'b1;
			end else begin
				timer_d.tick_within_cycle = timer_q.tick_within_cycle + 12'h001;
			end
		end
		if (cyc_inc) begin
			if (timer_q.cycle_number_field == link_regs_pkg::COUNT_LAST) begin
				timer_d.cycle_number_field = 13'h0000;
				timer_d.seconds_field = timer_q.seconds_field + 7'h01;
			end else begin
				timer_d.cycle_number_field = timer_q.cycle_number_field + 13'h0001;
			end
		end
	end

	// no reset on purpose: contents survive hard and soft reset
	always_ff @(posedge CLK_I) begin
		timer_q <= timer_d;
	end

	// cycle start sent at each boundary while master
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			CSP_TX_O <= 1'b0;
			CSP_TX_DATA_O <= 32'h0000_0000;
		end else begin
			CSP_TX_O <= cyc_inc && lctrl_q[link_regs_pkg::LC_MASTER];
			if (cyc_inc && lctrl_q[link_regs_pkg::LC_MASTER]) begin
				CSP_TX_DATA_O <= timer_d;
			end
		end
	end

	// ***********************************************
	// request filters
	// ***********************************************
	// bus reset beats a same-cycle software write
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			areq_hi_q <= link_regs_pkg::ZERO_RST;
			areq_lo_q <= link_regs_pkg::ZERO_RST;
			preq_hi_q <= link_regs_pkg::ZERO_RST;
			preq_lo_q <= link_regs_pkg::ZERO_RST;
			plim_q <= link_regs_pkg::ZERO_RST;
		end else begin
			if (BUS_RESET_I) begin
				areq_hi_q[30:0] <= 31'h0;
				areq_lo_q <= link_regs_pkg::ZERO_RST;
				preq_hi_q[30:0] <= 31'h0;
				preq_lo_q <= link_regs_pkg::ZERO_RST;
			end else if (WR_I) begin
				case (ADDR_I)
					link_regs_pkg::AREQ_HI_OFF: areq_hi_q <= WDATA_I;
					link_regs_pkg::AREQ_LO_OFF: areq_lo_q <= WDATA_I;
					link_regs_pkg::PREQ_HI_OFF: preq_hi_q <= WDATA_I;
					link_regs_pkg::PREQ_LO_OFF: preq_lo_q <= WDATA_I;
					default: ;
				endcase
			end
			// limit is untouched by soft and bus reset
			if (WR_I && (ADDR_I == link_regs_pkg::PHYS_LIM_OFF)) begin
				plim_q <= WDATA_I;
			end
		end
	end

	logic store_c, phys_c, in_range;
	// below limit << 16; software keeps limit at or under 0001_0000h
	assign in_range = REQ_I.offset < {plim_q[31:0], 16'h0000};
	assign store_c = REQ_I.resp || REQ_I.rom || src_enabled(areq_hi_q, areq_lo_q, REQ_I.src);
	assign phys_c = !REQ_I.resp && (REQ_I.rom || (in_range &&
		src_enabled(32'(preq_hi_q[30:0]), preq_lo_q, REQ_I.src) &&
		(REQ_I.local_bus || preq_hi_q[link_regs_pkg::ALL_BIT])));

	// one-cycle verdict per header
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			REQ_STORE_O <= 1'b0;
			REQ_DROP_O <= 1'b0;
			REQ_PHYS_O <= 1'b0;
		end else begin
			REQ_STORE_O <= REQ_I.valid && store_c;
			REQ_DROP_O <= REQ_I.valid && !store_c;
			REQ_PHYS_O <= REQ_I.valid && phys_c;
		end
	end

	// ***********************************************
	// transmit contexts (0 request, 1 response)
	// ***********************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ctx
			link_regs_pkg::ctx_state_e state_q;
			logic run_q;
			logic [4:0] evt_q;
			logic wr_ctrl, wr_ptr, start, resume;
			assign wr_ctrl = WR_I && (ADDR_I == 8'(link_regs_pkg::ATX_CTRL_OFF + gi * link_regs_pkg::ATX_STRIDE));
			assign wr_ptr = WR_I && (ADDR_I == 8'(link_regs_pkg::ATX_PTR_OFF + gi * link_regs_pkg::ATX_STRIDE));
			assign start = wr_ctrl && WDATA_I[link_regs_pkg::CC_RUN] && !run_q;
			assign resume = wr_ctrl && WDATA_I[link_regs_pkg::CC_WAKE] && WDATA_I[link_regs_pkg::CC_RUN];
			assign ctx_ctrl[gi] = {16'h0, run_q, 2'b00, 1'b0, (state_q == link_regs_pkg::CTX_DEAD),
				(state_q == link_regs_pkg::CTX_ACTIVE), 5'h00, evt_q};

			// context state; soft reset stops it
			always_ff @(posedge CLK_I or posedge RST_I) begin
				if (RST_I) begin
					state_q <= link_regs_pkg::CTX_IDLE;
					run_q <= 1'b0;
					evt_q <= link_regs_pkg::EVT_RST;
				end else if (soft_q) begin
					state_q <= link_regs_pkg::CTX_IDLE;
					run_q <= 1'b0;
				end else begin
					if (wr_ctrl) begin
						run_q <= WDATA_I[link_regs_pkg::CC_RUN];
					end
					case (state_q)
						link_regs_pkg::CTX_IDLE: begin
							if (start || resume) begin
								state_q <= link_regs_pkg::CTX_ACTIVE;
							end
						end
						link_regs_pkg::CTX_ACTIVE: begin
							if (wr_ctrl && !WDATA_I[link_regs_pkg::CC_RUN]) begin
								state_q <= link_regs_pkg::CTX_IDLE;
							end else if (CTX_EVT_I[gi].err) begin
								state_q <= link_regs_pkg::CTX_DEAD;
								evt_q <= CTX_EVT_I[gi].code;
							end else if (CTX_EVT_I[gi].done && CTX_EVT_I[gi].last) begin
								state_q <= link_regs_pkg::CTX_IDLE;
								evt_q <= CTX_EVT_I[gi].code;
							end
						end
						link_regs_pkg::CTX_DEAD: begin
							// only clearing run or a soft reset leaves the error state
							if (wr_ctrl && !WDATA_I[link_regs_pkg::CC_RUN]) begin
								state_q <= link_regs_pkg::CTX_IDLE;
							end
						end
						default: state_q <= link_regs_pkg::CTX_IDLE;
					endcase
				end
			end

			// command pointer; advances by count x 16 bytes per finished descriptor except the last, which only clears the count
			always_ff @(posedge CLK_I or posedge RST_I) begin
				if (RST_I) begin
					ptr_q[gi] <= link_regs_pkg::ZERO_RST;
				end else if (wr_ptr) begin
					ptr_q[gi] <= WDATA_I;
				end else if (state_q == link_regs_pkg::CTX_ACTIVE && CTX_EVT_I[gi].done && !CTX_EVT_I[gi].err) begin
					if (CTX_EVT_I[gi].last) begin
						ptr_q[gi][3:0] <= 4'h0;
					end else begin
						ptr_q[gi][31:4] <= ptr_q[gi][31:4] + 28'(ptr_q[gi][3:0]);
					end
				end
			end
			assign CTX_ACTIVE_O[gi] = (state_q == link_regs_pkg::CTX_ACTIVE);
			assign CTX_DESC_O[gi] = ptr_q[gi];

			property p_ctx_err;
				@(posedge CLK_I) disable iff (RST_I)
				(state_q == link_regs_pkg::CTX_ACTIVE && CTX_EVT_I[gi].err && !wr_ctrl && !soft_q && !wr_ptr)
				|=> (ctx_ctrl[gi][link_regs_pkg::CC_DEAD] && !CTX_ACTIVE_O[gi] && ptr_q[gi] == $past(ptr_q[gi]));
			endproperty
			a_ctx_err: assert property (p_ctx_err) else $error("context not dead after error");
		end
	endgenerate

	// ***********************************************
	// checks
	// ***********************************************
	property p_hold;
		@(posedge CLK_I) disable iff (RST_I)
		(ext_mode && !wr_timer && timer_q.tick_within_cycle == link_regs_pkg::OFFSET_LAST && !ext_pulse)
		|=> $stable(timer_q);
	endproperty
	a_hold: assert property (p_hold) else $error("offset moved while waiting for tick");
	property p_ext_clr;
		@(posedge CLK_I) disable iff (RST_I)
		(ext_mode && ext_pulse && !wr_timer) |=> (timer_q.tick_within_cycle == 12'h000);
	endproperty
	a_ext_clr: assert property (p_ext_clr) else $error("offset not cleared by tick");
	property p_wrap;
		@(posedge CLK_I) disable iff (RST_I)
		(!ext_mode && tick_q && !wr_timer && !(CSP_VALID_I && !lctrl_q[link_regs_pkg::LC_MASTER])
		&& timer_q.tick_within_cycle == link_regs_pkg::OFFSET_LAST
		&& timer_q.cycle_number_field == link_regs_pkg::COUNT_LAST)
		|=> (timer_q.tick_within_cycle == 12'h000 && timer_q.cycle_number_field == 13'h0000
		&& timer_q.seconds_field == $past(timer_q.seconds_field) + 7'h01);
	endproperty
	a_wrap: assert property (p_wrap) else $error("cycle rollover wrong");

	property p_rx_load;
		@(posedge CLK_I) disable iff (RST_I)
		(!lctrl_q[link_regs_pkg::LC_MASTER] && CSP_VALID_I && !wr_timer) |=> (timer_q == $past(CSP_DATA_I));
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("cycle start not loaded");
	property p_tx;
		@(posedge CLK_I) disable iff (RST_I)
		CSP_TX_O |-> (CSP_TX_DATA_O == timer_q && timer_q.tick_within_cycle == 12'h000);
	endproperty
	a_tx: assert property (p_tx) else $error("cycle start data differs from timer");
	property p_filter;
		@(posedge CLK_I) disable iff (RST_I)
		(REQ_I.valid && !REQ_I.resp && !REQ_I.rom && !areq_hi_q[link_regs_pkg::ALL_BIT]
		&& !src_enabled(areq_hi_q, areq_lo_q, REQ_I.src)) |=> (REQ_DROP_O && !REQ_STORE_O);
	endproperty
	a_filter: assert property (p_filter) else $error("unlisted source stored");

	property p_bypass;
		@(posedge CLK_I) disable iff (RST_I)
		(REQ_I.valid && (REQ_I.resp || REQ_I.rom)) |=> (REQ_STORE_O && (REQ_PHYS_O == $past(!REQ_I.resp)));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass packet filtered");

	property p_bus_reset;
		@(posedge CLK_I) disable iff (RST_I)
		BUS_RESET_I |=> (areq_lo_q == 32'h0000_0000 && areq_hi_q[30:0] == 31'h0 && preq_lo_q == 32'h0000_0000
		&& areq_hi_q[31] == $past(areq_hi_q[31]) && preq_hi_q == {$past(preq_hi_q[31]), 31'h0});
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset filter clear wrong");
endmodule
`default_nettype wire

// File: dv/remote_node_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// remote bus nodes: cycle start, requests, 8 kHz source
// ***************************************
module remote_node_model (
	input wire logic clk_i,
	output logic csp_valid_o,
	output logic [31:0] csp_data_o,
	output link_regs_pkg::req_hdr_s req_o,
	output logic tick_o
);
	// idle state at time zero
	initial begin
		csp_valid_o = 1'b0;
		csp_data_o = 32'h0000_0000;
		req_o = '0;
		tick_o = 1'b0;
	end
	// one cycle start packet; data inverted afterwards so stale data never matches
	task automatic send_csp(input logic [31:0] d);
		@(posedge clk_i);
		csp_valid_o <= 1'b1;
		csp_data_o <= d;
		@(posedge clk_i);
		csp_valid_o <= 1'b0;
		csp_data_o <= ~d;
	endtask
	// one request header; fields scrambled once released
	task automatic send_req(input link_regs_pkg::req_hdr_s h);
		@(posedge clk_i);
		req_o <= h;
		@(posedge clk_i);
		req_o <= {1'b0, ~h[57:0]};
	endtask
	// external tick, held several cycles for the pin synchroniser
	task automatic pulse_tick();
		@(posedge clk_i);
		tick_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		tick_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: dv/tb_link_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_link_regs;
	// ***************************************
	// stimulus and observed signals
	// ***************************************
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, bus_rst = 1'b0;
	logic csp_v, tick, csp_tx, st_o, dr_o, ph_o;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, csp_d, csp_txd, d, t, af_hi, af_lo, pf_hi, pf_lo, lim;
	link_regs_pkg::req_hdr_s req, h;
	link_regs_pkg::ctx_evt_s [1:0] ctx_evt = '0;
	logic [1:0] act;
	logic [1:0][31:0] desc;
	logic [7:0] c0, p0;
	int seed = 72, n, miscompares = 0, checks_done = 0;
	// 200 MHz
	initial forever #2.5 clk = ~clk;
	link_regs dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
		.RDATA_O(rdata), .EXT_8K_TICK_I(tick), .CSP_VALID_I(csp_v), .CSP_DATA_I(csp_d), .CSP_TX_O(csp_tx),
		.CSP_TX_DATA_O(csp_txd), .BUS_RESET_I(bus_rst), .REQ_I(req), .REQ_STORE_O(st_o), .REQ_DROP_O(dr_o),
		.REQ_PHYS_O(ph_o), .CTX_EVT_I(ctx_evt), .CTX_ACTIVE_O(act), .CTX_DESC_O(desc));
	remote_node_model remote (.clk_i(clk), .csp_valid_o(csp_v), .csp_data_o(csp_d), .req_o(req), .tick_o(tick));
	// ***************************************
	// bus tasks and expectations
	// ***************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		`CHK(v, e)
	endtask
	// store/drop/physical decision; source 63 has no enable bit of its own
	function automatic logic [2:0] exp_req(input link_regs_pkg::req_hdr_s q);
		logic [63:0] af;
		logic [63:0] pf;
		logic s;
		logic p;
		af = {af_hi, af_lo};
		pf = {pf_hi, pf_lo};
		s = q.resp | q.rom | af[63] | (q.src != 6'h3F && af[q.src]);
		p = !q.resp & (q.rom | ((q.src != 6'h3F && pf[q.src]) & (q.offset < {lim, 16'h0000}) & (q.local_bus | pf[63])));
		return {s, !s, p};
	endfunction
	task automatic do_req(input link_regs_pkg::req_hdr_s q);
		remote.send_req(q);
		@(negedge clk);
		`CHK({st_o, dr_o, ph_o}, exp_req(q))
	endtask
	task automatic ctx_event(input int c, input logic [7:0] e);
		@(posedge clk);
		ctx_evt[c] <= e;
		@(posedge clk);
		ctx_evt[c] <= 8'h00;
		@(negedge clk);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// reset values, unmapped write and read
		wr(8'hF0, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) chk_rd(8'h08 + 8'(i * 4), 32'h0000_0000);
		chk_rd(8'hF0, 32'h0000_0000);
		$display("test reset_values done");
		// master: wrap of offset, cycle and seconds into one cycle start
		t = {7'h7F, 13'd7999, 12'd3060};
		wr(link_regs_pkg::CYC_TIMER_OFF, t);
		chk_rd(link_regs_pkg::CYC_TIMER_OFF, t);
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0005);
		n = 0;
		while (csp_tx !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		`CHK(csp_txd, 32'h0000_0000)
		// 12 counts of about 8.14 clocks, first one up to a period late, plus enable and output flops
		`CHK(n >= 92 && n <= 101, 1'b1)
		$display("test master_wrap done");
		// external tick mode: offset parks at 3071, tick clears it
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0000);
		wr(link_regs_pkg::CYC_TIMER_OFF, {7'h01, 13'd100, 12'd3065});
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0007);
		repeat (300) @(negedge clk);
		chk_rd(link_regs_pkg::CYC_TIMER_OFF, {7'h01, 13'd100, 12'd3071});
		remote.pulse_tick();
		repeat (10) @(negedge clk);
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0000);
		rd(link_regs_pkg::CYC_TIMER_OFF, d);
		`CHK(d[31:12], {7'h01, 13'd101})
		`CHK(d[11:0] < 12'd8, 1'b1)
		$display("test external_tick done");
		// slave: received cycle start loads, then free counting
		t = $random(seed);
		t = {t[31:25], 1'b0, t[23:12], 1'b0, t[10:0]};
		remote.send_csp(t);
		chk_rd(link_regs_pkg::CYC_TIMER_OFF, t);
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0004);
		repeat (100) @(negedge clk);
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0000);
		rd(link_regs_pkg::CYC_TIMER_OFF, d);
		`CHK(d[31:12], t[31:12])
		`CHK(d[11:0] - t[11:0] >= 12'd11 && d[11:0] - t[11:0] <= 12'd14, 1'b1)
		$display("test slave_load done");
		// filters, limit within the allowed maximum
		af_hi = $random(seed);
		af_lo = $random(seed);
		pf_hi = $random(seed);
		pf_lo = $random(seed);
		lim = {$random(seed)} % 32'h0001_0001;
		wr(link_regs_pkg::AREQ_HI_OFF, af_hi);
		wr(link_regs_pkg::AREQ_LO_OFF, af_lo);
		wr(link_regs_pkg::PREQ_HI_OFF, pf_hi);
		wr(link_regs_pkg::PREQ_LO_OFF, pf_lo);
		wr(link_regs_pkg::PHYS_LIM_OFF, lim);
		// soft reset keeps timer and limit; timer is stopped, so a known value goes in first
		wr(link_regs_pkg::CYC_TIMER_OFF, t);
		wr(link_regs_pkg::LINK_CTRL_OFF, 32'h0000_0008);
		chk_rd(link_regs_pkg::CYC_TIMER_OFF, t);
		chk_rd(link_regs_pkg::PHYS_LIM_OFF, lim);
		for (int i = 0; i < 48; i++) begin
			h = 59'({$random(seed), $random(seed)});
			h.valid = 1'b1;
			// even passes sit on the range boundary
			if (i % 2 == 0) h.offset = {lim, 16'h0000} - 48'(i % 3);
			do_req(h);
		end
		// bus reset keeps only the accept-all bit and the all-buses bit
		@(posedge clk);
		bus_rst <= 1'b1;
		@(posedge clk);
		bus_rst <= 1'b0;
		af_hi = af_hi & 32'h8000_0000;
		af_lo = 32'h0000_0000;
		pf_hi = pf_hi & 32'h8000_0000;
		pf_lo = 32'h0000_0000;
		chk_rd(link_regs_pkg::AREQ_HI_OFF, af_hi);
		chk_rd(link_regs_pkg::AREQ_LO_OFF, af_lo);
		chk_rd(link_regs_pkg::PREQ_HI_OFF, pf_hi);
		chk_rd(link_regs_pkg::PREQ_LO_OFF, pf_lo);
		h = '0;
		h.valid = 1'b1;
		h.src = 6'h05;
		do_req(h);
		$display("test filters done");
		// both transmit contexts: start, advance, finish, wake, error
		for (int c = 0; c < 2; c++) begin
			c0 = link_regs_pkg::ATX_CTRL_OFF + 8'(c * 8);
			p0 = link_regs_pkg::ATX_PTR_OFF + 8'(c * 8);
			wr(p0, 32'h1000_0002);
			wr(c0, 32'h0000_8000);
			@(negedge clk);
			`CHK(act, 2'(1 << c))
			ctx_event(c, 8'h80);
			`CHK(desc[c], 32'h1000_0022)
			ctx_event(c, 8'hB1);
			`CHK(act[c], 1'b0)
			`CHK(desc[c], 32'h1000_0020)
			chk_rd(c0, 32'h0000_8011);
			// run still set after completion: only the wake bit may restart it
			wr(c0, 32'h0000_8000);
			@(negedge clk);
			`CHK(act[c], 1'b0)
			wr(c0, 32'h0000_9000);
			@(negedge clk);
			`CHK(act[c], 1'b1)
			ctx_event(c, 8'h4E);
			chk_rd(c0, 32'h0000_880E);
			`CHK(desc[c], 32'h1000_0020)
			wr(c0, 32'h0000_0000);
		end
		$display("test contexts done");
		// hardware reset leaves the timer alone
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		chk_rd(link_regs_pkg::CYC_TIMER_OFF, t);
		$display("test hard_reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
